// file: verilog/pmrb_pkg.sv
package pmrb_pkg;

  // Register port geometry
  localparam int unsigned PMRB_AW = 8;
  localparam int unsigned PMRB_DW = 32;

  // Register indices as the host addresses them
  localparam logic [7:0] PMRB_IDX_RMS = 8'h20;
  localparam logic [7:0] PMRB_IDX_POWER = 8'h21;
  localparam logic [7:0] PMRB_IDX_APPARENT = 8'h22;
  localparam logic [7:0] PMRB_IDX_NPTS = 8'h25;
  localparam logic [7:0] PMRB_IDX_RMS_AVG_S = 8'h26;
  localparam logic [7:0] PMRB_IDX_RMS_AVG_L = 8'h27;
  localparam logic [7:0] PMRB_IDX_PACT_AVG_S = 8'h28;
  localparam logic [7:0] PMRB_IDX_PACT_AVG_L = 8'h29;

  // Field positions
  localparam int unsigned PMRB_LO_LSB = 0;
  localparam int unsigned PMRB_HI_LSB = 16;
  localparam int unsigned PMRB_HALF_W = 16;
  localparam int unsigned PMRB_PF_LSB = 16;
  localparam int unsigned PMRB_PF_W = 11;
  localparam int unsigned PMRB_ANGLE_BIT = 27;
  localparam int unsigned PMRB_PFSIGN_BIT = 28;
  localparam int unsigned PMRB_NPTS_LSB = 0;
  localparam int unsigned PMRB_NPTS_W = 10;

  // Limits and reset values
  localparam logic [9:0] PMRB_NPTS_MAX = 10'h3ff;
  localparam logic [15:0] PMRB_HALF_RST = 16'h0000;
  localparam logic [31:0] PMRB_WORD_RST = 32'h0000_0000;

  // Averaging: window of 2**select result updates
  localparam int unsigned PMRB_AVG_SEL_W = 4;
  localparam int unsigned PMRB_LANES = 3;
  localparam int unsigned PMRB_LANE_W = 17;
  localparam int unsigned PMRB_ACC_W = 32;
  localparam int unsigned PMRB_CNT_W = 16;
  localparam int unsigned PMRB_LANE_V = 0;
  localparam int unsigned PMRB_LANE_I = 1;
  localparam int unsigned PMRB_LANE_P = 2;

  typedef logic [PMRB_LANES-1:0][PMRB_LANE_W-1:0] pmrb_lanes_t;
  typedef logic [PMRB_LANES-1:0][PMRB_HALF_W-1:0] pmrb_means_t;

  // One set of results from the measurement datapath
  typedef struct packed {
    logic [15:0] vrms;
    logic [15:0] irms;
    logic [15:0] pactive;
    logic [15:0] pimag;
    logic [15:0] papparent;
    logic [10:0] pfactor;
    logic posangle;
    logic pospf;
  } pmrb_meas_t;

  // Per-sample strobes from the datapath
  typedef struct packed {
    logic sample;
    logic vzero_full;
  } pmrb_tick_t;

endpackage : pmrb_pkg

// file: verilog/pmrb_avg.sv
`timescale 1ns/1ps
`default_nettype none

module pmrb_avg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Incoming results
  input wire logic in_valid,
  input wire pmrb_pkg::pmrb_lanes_t in_lanes,
  input wire logic [pmrb_pkg::PMRB_AVG_SEL_W-1:0] sel,
  // Averaged results
  output logic out_valid,
  output pmrb_pkg::pmrb_means_t out_means
);
  import pmrb_pkg::*;

  typedef struct packed {
    logic [PMRB_LANES-1:0][PMRB_ACC_W-1:0] acc;
    logic [PMRB_CNT_W-1:0] cnt;
    pmrb_means_t mean;
    logic done;
  } pmrb_avg_st_t;

  pmrb_avg_st_t st;
  pmrb_avg_st_t next_st;
  logic [PMRB_CNT_W-1:0] window;
  logic [PMRB_CNT_W-1:0] cnt_inc;
  logic [PMRB_LANES-1:0][PMRB_ACC_W-1:0] sum;

  assign window = PMRB_CNT_W'(1) << sel;
  assign cnt_inc = st.cnt + PMRB_CNT_W'(1);

  genvar g;
  generate
    for (g = 0; g < PMRB_LANES; g++) begin : g_lane
      assign sum[g] = st.acc[g] +
        {{(PMRB_ACC_W-PMRB_LANE_W){in_lanes[g][PMRB_LANE_W-1]}}, in_lanes[g]};
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (in_valid) begin
      next_st.acc = sum;
      next_st.cnt = cnt_inc;
      // Window closes; also closes if select shrank mid-window
      if (cnt_inc >= window) begin
        for (int k = 0; k < PMRB_LANES; k++) begin
          next_st.mean[k] = PMRB_HALF_W'($signed(sum[k]) >>> sel);
        end
        next_st.acc = '0;
        next_st.cnt = '0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.done;
  assign out_means = st.mean;

endmodule : pmrb_avg

`default_nettype wire

// file: verilog/pmrb_bank.sv
// Summary of operation
// - Voltage RMS, unsigned all-fraction, low half word
// - Current RMS, signed Q15, high half word
// - Active power, signed Q15, low half
// - Reactive power, unsigned all-fraction, high half
// - Apparent power, unsigned all-fraction, low half
// - Power factor, signed 11-bit, bits 26:16
// - Bit 27: current leads 0, lags 1
// - Bit 28: generated 0, consumed 1
// - Sample count in bits 9:0, 0..1023
// - Count samples between full-cycle voltage zero crossings
// - Short RMS averages, half zeroed by select
// - Long RMS averages, half zeroed by select
// - Short active power average in low half
// - Long active power average in low half
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pmrb_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host register port
  input wire logic [pmrb_pkg::PMRB_AW-1:0] addr,
  input wire logic [pmrb_pkg::PMRB_DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [pmrb_pkg::PMRB_DW-1:0] rd_data,
  output logic wr_refused,
  // Measurement datapath
  input wire logic meas_valid,
  input wire pmrb_pkg::pmrb_meas_t meas,
  input wire pmrb_pkg::pmrb_tick_t tick,
  // Averaging configuration
  input wire logic [pmrb_pkg::PMRB_AVG_SEL_W-1:0] avg_sel_short,
  input wire logic [pmrb_pkg::PMRB_AVG_SEL_W-1:0] avg_sel_long,
  input wire logic iavg_sel
);
  import pmrb_pkg::*;

  typedef struct packed {
    pmrb_meas_t res;
    logic [PMRB_NPTS_W-1:0] pts_run;
    logic pts_sat;
    logic [PMRB_NPTS_W-1:0] numpts;
    logic [PMRB_DW-1:0] rd_data;
    logic wr_refused;
    logic res_stored;
    logic avg_seen;
  } pmrb_bank_st_t;

  pmrb_bank_st_t st;
  pmrb_bank_st_t next_st;

  pmrb_lanes_t avg_lanes;
  logic avg_short_valid;
  logic avg_long_valid;
  pmrb_means_t avg_short;
  pmrb_means_t avg_long;
  logic [PMRB_DW-1:0] word;

  // Lanes widened to 17 bits; only voltage is unsigned
  assign avg_lanes[PMRB_LANE_V] = {1'b0, st.res.vrms};
  assign avg_lanes[PMRB_LANE_I] = {st.res.irms[15], st.res.irms};
  assign avg_lanes[PMRB_LANE_P] = {st.res.pactive[15], st.res.pactive};

  // Averages advance one step per stored result set
  logic res_stored;
  assign res_stored = st.res_stored;

  pmrb_avg u_avg_short (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(res_stored),
    .in_lanes(avg_lanes),
    .sel(avg_sel_short),
    .out_valid(avg_short_valid),
    .out_means(avg_short)
  );

  pmrb_avg u_avg_long (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(res_stored),
    .in_lanes(avg_lanes),
    .sel(avg_sel_long),
    .out_valid(avg_long_valid),
    .out_means(avg_long)
  );

  // RMS average pair with one half forced to zero by the select
  function automatic logic [PMRB_DW-1:0] rms_pair(
    input pmrb_means_t m,
    input logic isel
  );
    logic [PMRB_DW-1:0] w;
    w = PMRB_WORD_RST;
    if (isel) begin
      w[PMRB_HI_LSB +: PMRB_HALF_W] = m[PMRB_LANE_I];
      w[PMRB_LO_LSB +: PMRB_HALF_W] = PMRB_HALF_RST;
    end else begin
      w[PMRB_LO_LSB +: PMRB_HALF_W] = m[PMRB_LANE_V];
      w[PMRB_HI_LSB +: PMRB_HALF_W] = PMRB_HALF_RST;
    end
    return w;
  endfunction : rms_pair

  // Read word assembly; everything not placed stays zero
  always_comb begin
    word = PMRB_WORD_RST;
    unique case (addr)
      PMRB_IDX_RMS: begin
        word[PMRB_LO_LSB +: PMRB_HALF_W] = st.res.vrms;
        word[PMRB_HI_LSB +: PMRB_HALF_W] = st.res.irms;
      end
      PMRB_IDX_POWER: begin
        word[PMRB_LO_LSB +: PMRB_HALF_W] = st.res.pactive;
        word[PMRB_HI_LSB +: PMRB_HALF_W] = st.res.pimag;
      end
      PMRB_IDX_APPARENT: begin
        word[PMRB_LO_LSB +: PMRB_HALF_W] = st.res.papparent;
        word[PMRB_PF_LSB +: PMRB_PF_W] = st.res.pfactor;
        word[PMRB_ANGLE_BIT] = st.res.posangle;
        word[PMRB_PFSIGN_BIT] = st.res.pospf;
      end
      PMRB_IDX_NPTS: begin
        word[PMRB_NPTS_LSB +: PMRB_NPTS_W] = st.numpts;
      end
      PMRB_IDX_RMS_AVG_S: begin
        word = rms_pair(avg_short, iavg_sel);
      end
      PMRB_IDX_RMS_AVG_L: begin
        word = rms_pair(avg_long, iavg_sel);
      end
      PMRB_IDX_PACT_AVG_S: begin
        word[PMRB_LO_LSB +: PMRB_HALF_W] = avg_short[PMRB_LANE_P];
      end
      PMRB_IDX_PACT_AVG_L: begin
        word[PMRB_LO_LSB +: PMRB_HALF_W] = avg_long[PMRB_LANE_P];
      end
      default: begin
        word = PMRB_WORD_RST;
      end
    endcase
  end

  always_comb begin
    next_st = st;

    // Results change only from the datapath
    if (meas_valid) begin
      next_st.res = meas;
    end

    // Sample counting over one full voltage cycle
    if (tick.vzero_full) begin
      next_st.numpts = st.pts_run;
      next_st.pts_run = tick.sample ? PMRB_NPTS_W'(1) : '0;
      next_st.pts_sat = 1'b0;
    end else if (tick.sample) begin
      // Saturate at the field's largest value
      if (st.pts_run == PMRB_NPTS_MAX) begin
        next_st.pts_sat = 1'b1;
      end else begin
        next_st.pts_run = st.pts_run + PMRB_NPTS_W'(1);
      end
    end

    // Host port: read data in the next cycle only
    next_st.rd_data = rd_en ? word : PMRB_WORD_RST;

    // Write data is dropped; the write is only flagged for one cycle
    next_st.wr_refused = wr_en;

    // A stored result set feeds the averagers one cycle later
    next_st.res_stored = meas_valid;

    // Averager valids are status only inside this block
    next_st.avg_seen = st.avg_seen | avg_short_valid | avg_long_valid |
      st.pts_sat;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign wr_refused = st.wr_refused;

endmodule : pmrb_bank

`default_nettype wire

// file: test/pmrb_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module pmrb_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host port
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic wr_refused,
  // Datapath
  input wire logic meas_valid,
  input wire pmrb_pkg::pmrb_meas_t meas,
  input wire logic iavg_sel
);
  import pmrb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_WR_REFUSE: assert property (wr_en |=> wr_refused)
    else $error("write not refused");
  AST_NO_REFUSE: assert property (!wr_en |=> !wr_refused)
    else $error("stray refusal");
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data outside its slot");
  AST_RMS_WORD: assert property (
    rd_en && addr == 8'h20 && $past(meas_valid) && $past(rst_b)
    |=> rd_data == {$past(meas.irms, 2), $past(meas.vrms, 2)})
    else $error("rms word layout");
  AST_POWER_WORD: assert property (
    rd_en && addr == 8'h21 && $past(meas_valid) && $past(rst_b)
    |=> rd_data == {$past(meas.pimag, 2), $past(meas.pactive, 2)})
    else $error("power word layout");
  AST_APPARENT_WORD: assert property (
    rd_en && addr == 8'h22 && $past(meas_valid) && $past(rst_b)
    |=> rd_data == {3'h0, $past(meas.pospf, 2), $past(meas.posangle, 2),
    $past(meas.pfactor, 2), $past(meas.papparent, 2)})
    else $error("apparent word layout");
  AST_NPTS_RANGE: assert property (
    rd_en && addr == 8'h25 |=> rd_data[31:10] == 22'h0)
    else $error("sample count spills");
  AST_UNMAPPED: assert property (
    rd_en && !(addr inside {[8'h20:8'h22], [8'h25:8'h29]})
    |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  AST_AVG_HALF: assert property (
    rd_en && addr inside {8'h26, 8'h27}
    |=> ($past(iavg_sel) ? rd_data[15:0] : rd_data[31:16]) == 16'h0)
    else $error("average half not zeroed");
  AST_PACT_HI: assert property (
    rd_en && addr inside {8'h28, 8'h29} |=> rd_data[31:16] == 16'h0)
    else $error("power average high half");

  cover property (wr_en ##1 wr_refused);
  cover property (rd_en && addr == 8'h25);
  cover property (meas_valid ##1 meas_valid);
endmodule : pmrb_chk

`default_nettype wire

// file: test/pmrb_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end

module pmrb_bank_test;
  import pmrb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic meas_valid = 1'b0;
  logic iavg_sel = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] d;
  logic [31:0] rd_data;
  logic wr_refused;
  pmrb_meas_t meas = '0;
  pmrb_tick_t tick = '0;
  logic [3:0] sel_s = 4'h0;
  logic [3:0] sel_l = 4'h0;
  int error_cnt = 0;
  int checks = 0;

  always #5 clk = ~clk;

  pmrb_bank u_dut (.clk, .rst_b, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .wr_refused, .meas_valid, .meas, .tick, .avg_sel_short(sel_s),
    .avg_sel_long(sel_l), .iavg_sel);

  task rst;
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : rst

  task ld(input pmrb_meas_t m);
    meas <= m;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
  endtask : ld

  task rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task t_fields;
    pmrb_meas_t m;
    logic [31:0] exp_w;
    for (int k = 0; k < 2; k++) begin
      m = '{vrms: 16'hf123 + 16'(k), irms: 16'h8001, pactive: 16'h9abc,
        pimag: 16'hfedc, papparent: 16'h1357, pfactor: 11'h400 + 11'(k),
        posangle: k[0], pospf: !k[0]};
      ld(m);
      rd(8'h20);
      `CHK(d, {m.irms, m.vrms})
      ld(m);
      rd(8'h21);
      `CHK(d, {m.pimag, m.pactive})
      ld(m);
      rd(8'h22);
      exp_w = {3'h0, m.pospf, m.posangle, m.pfactor, m.papparent};
      `CHK(d, exp_w)
    end
  endtask : t_fields

  task t_ro;
    addr <= 8'h20;
    wr_data <= 32'hffff_ffff;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 `CHK(wr_refused, 1'b1)
    rd(8'h20);
    `CHK(d, 32'h8001_f124)
    rd(8'h23);
    `CHK(d, 32'h0)
    rd(8'h2a);
    `CHK(d, 32'h0)
  endtask : t_ro

  task t_cnt(input int n, input logic [31:0] exp);
    tick <= 2'b01;
    @(posedge clk);
    repeat (n) begin
      tick <= 2'b10;
      @(posedge clk);
    end
    tick <= 2'b01;
    @(posedge clk);
    tick <= 2'b00;
    rd(8'h25);
    `CHK(d, exp)
  endtask : t_cnt

  task feed;
    pmrb_meas_t m;
    m = '0;
    for (int k = 1; k <= 4; k++) begin
      m.vrms = 16'(k * 100);
      m.irms = 16'(k * 1000);
      m.pactive = 16'(-4 * k);
      meas <= m;
      meas_valid <= 1'b1;
      @(posedge clk);
    end
    meas_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : feed

  task t_avg;
    rst;
    sel_s <= 4'h1;
    sel_l <= 4'h2;
    feed;
    rd(8'h26);
    `CHK(d, 32'h0000_015e)
    rd(8'h27);
    `CHK(d, 32'h0000_00fa)
    rd(8'h28);
    `CHK(d, 32'h0000_fff2)
    rd(8'h29);
    `CHK(d, 32'h0000_fff6)
    iavg_sel <= 1'b1;
    feed;
    rd(8'h26);
    `CHK(d, 32'h0dac_0000)
    rd(8'h27);
    `CHK(d, 32'h09c4_0000)
  endtask : t_avg

  task final_report;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial begin
    #100us;
    error_cnt++;
    final_report;
  end

  initial begin
    rst;
    t_fields;
    t_ro;
    t_cnt(5, 32'h5);
    t_cnt(0, 32'h0);
    t_cnt(1023, 32'h3ff);
    t_cnt(1100, 32'h3ff);
    t_avg;
    final_report;
  end
endmodule : pmrb_bank_test

bind pmrb_bank pmrb_chk u_chk (.clk, .rst_b, .addr, .wr_en, .rd_en, .rd_data,
  .wr_refused, .meas_valid, .meas, .iavg_sel);

`default_nettype wire
